// file: verilog/csr_pkg.sv
// package: timing constants, state enum and carrier structs for supervisor
package csr_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned NS_PER_S = 1000000000;
   // times in their own units, as printed
   localparam int unsigned RESET_HOLD_MS = 250;
   localparam int unsigned WDOG_SHORT_MS = 150;
   localparam int unsigned WDOG_MID_MS = 600;
   localparam int unsigned WDOG_LONG_MS = 1200;
   localparam int unsigned PB_IGNORE_MS = 1;
   localparam int unsigned PB_DELAY_MS = 4;
   localparam int unsigned SUPPLY_FALL_NS = 100;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   // least times are whole multiples of CYC_PER_MS, which rounds down; longest times round down, never below one cycle
   localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CYC_PER_MS;
   localparam int unsigned WDOG_SHORT_CYC = WDOG_SHORT_MS * CYC_PER_MS;
   localparam int unsigned WDOG_MID_CYC = WDOG_MID_MS * CYC_PER_MS;
   localparam int unsigned WDOG_LONG_CYC = WDOG_LONG_MS * CYC_PER_MS;
   localparam int unsigned PB_DELAY_CYC = PB_DELAY_MS * CYC_PER_MS;
   localparam int unsigned SUPPLY_FALL_CYC_RAW =
      SUPPLY_FALL_NS / (NS_PER_S / CLK_HZ);
   localparam int unsigned SUPPLY_FALL_CYC =
      (SUPPLY_FALL_CYC_RAW < 1) ? 1 : SUPPLY_FALL_CYC_RAW;
   localparam int unsigned CNT_W = 27;
   // timeout select codes of the three-level pin
   localparam logic [1:0] TSEL_GND = 2'h0;
   localparam logic [1:0] TSEL_OPEN = 2'h1;
   localparam logic [1:0] TSEL_VCC = 2'h2;
   localparam logic RST_ACTIVE_RESET = 1'h1;

   typedef enum logic [2:0] {
      CSR_HOLD = 3'h1,
      CSR_RUN = 3'h2,
      CSR_ASSERT = 3'h4
   } csr_state_e;

   // synchronised pin inputs
   typedef struct packed {
      logic supply_ok;
      logic strobe_n;
      logic manual_n;
   } csr_pins_s;

   // complementary reset pair
   typedef struct packed {
      logic reset;
      logic reset_n;
   } csr_reset_s;
endpackage

// file: verilog/csr_supervisor.sv
// processor supervisor: supply, watchdog and manual reset sequencing
////////////////////////////////////////////////////////////////////////////
module csr_supervisor #(
   parameter int unsigned HOLD_CYC = csr_pkg::RESET_HOLD_CYC,
   parameter int unsigned WD_SHORT_CYC = csr_pkg::WDOG_SHORT_CYC,
   parameter int unsigned WD_MID_CYC = csr_pkg::WDOG_MID_CYC,
   parameter int unsigned WD_LONG_CYC = csr_pkg::WDOG_LONG_CYC,
   parameter int unsigned PB_CYC = csr_pkg::PB_DELAY_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic supply_ok_i,
   input wire logic tolerance_select_i,
   input wire logic [1:0] timeout_select_i,
   input wire logic watchdog_strobe_n_i,
   input wire logic manual_override_n_i,
   output logic trip_level_low_o,
   output logic reset_o,
   output logic reset_n_o
);
   ////////////////////////////////////////////////////////////////////////
   // synchronisers; stage one feeds only stage two
   csr_pkg::csr_pins_s sync1_q, sync2_q, sync1_d;
   logic strobe_prev_q;
   logic [1:0] tsel_meta_q, tsel_q;
   always_comb begin
      sync1_d.supply_ok = supply_ok_i;
      sync1_d.strobe_n = watchdog_strobe_n_i;
      sync1_d.manual_n = manual_override_n_i;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // power-up counts as supply low; strobe and override idle high
         sync1_q <= 3'h3;
         sync2_q <= 3'h3;
         strobe_prev_q <= 1'h1;
         tsel_meta_q <= csr_pkg::TSEL_GND;
         tsel_q <= csr_pkg::TSEL_GND;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync1_q;
         strobe_prev_q <= sync2_q.strobe_n;
         tsel_meta_q <= timeout_select_i;
         tsel_q <= tsel_meta_q;
      end
   end
   // comparator threshold steered by the pin; high selects the lower trip
   assign trip_level_low_o = tolerance_select_i;

   ////////////////////////////////////////////////////////////////////////
   // debounce: low must persist PB_CYC before it counts
   logic [csr_pkg::CNT_W-1:0] pb_cnt_q, pb_cnt_d;
   logic pb_active_q, pb_active_d;
   always_comb begin
      pb_cnt_d = '0;
      pb_active_d = 1'h0;
      if (!sync2_q.manual_n) begin
         pb_active_d = pb_active_q;
         pb_cnt_d = pb_cnt_q;
         if (pb_cnt_q >= csr_pkg::CNT_W'(PB_CYC - 1))
            pb_active_d = 1'h1;
         else
            pb_cnt_d = pb_cnt_q + 1'h1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pb_cnt_q <= '0;
         pb_active_q <= 1'h0;
      end else begin
         pb_cnt_q <= pb_cnt_d;
         pb_active_q <= pb_active_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset sequencer
   csr_pkg::csr_state_e state_q, state_d;
   logic [csr_pkg::CNT_W-1:0] cnt_q, cnt_d, wd_limit;
   logic strobe_fall, cause, wd_expired;
   assign strobe_fall = strobe_prev_q & ~sync2_q.strobe_n;
   always_comb begin
      case (tsel_q)
         csr_pkg::TSEL_GND: wd_limit = csr_pkg::CNT_W'(WD_SHORT_CYC - 1);
         csr_pkg::TSEL_OPEN: wd_limit = csr_pkg::CNT_W'(WD_MID_CYC - 1);
         default: wd_limit = csr_pkg::CNT_W'(WD_LONG_CYC - 1);
      endcase
   end
   assign cause = ~sync2_q.supply_ok | pb_active_q;
   assign wd_expired = (state_q == csr_pkg::CSR_RUN) && (cnt_q >= wd_limit);
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         csr_pkg::CSR_HOLD: begin
            if (cause) begin
               cnt_d = '0;
            end else if (cnt_q >= csr_pkg::CNT_W'(HOLD_CYC - 1)) begin
               state_d = csr_pkg::CSR_RUN;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + 1'h1;
            end
         end
         csr_pkg::CSR_RUN: begin
            if (cause) begin
               state_d = csr_pkg::CSR_HOLD;
               cnt_d = '0;
            end else if (wd_expired) begin
               state_d = csr_pkg::CSR_HOLD;
               cnt_d = '0;
            end else if (strobe_fall) begin
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + 1'h1;
            end
         end
         default: begin
            state_d = csr_pkg::CSR_HOLD;
            cnt_d = '0;
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= csr_pkg::CSR_HOLD;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs from the state register only: supply loss takes three
   // clocks through the synchroniser, inside the 100 ns bound, and a
   // glitch too short to catch cannot make a pulse below the hold time
   csr_pkg::csr_reset_s rst_out;
   always_comb begin
      rst_out.reset = (state_q != csr_pkg::CSR_RUN);
      rst_out.reset_n = ~rst_out.reset;
   end
   assign reset_o = rst_out.reset;
   assign reset_n_o = rst_out.reset_n;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   // run lengths for the length checks; far cheaper than deep $past
   int unsigned low_run_q, man_low_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) low_run_q <= 0;
      else if (reset_o) low_run_q <= low_run_q + 1;
      else low_run_q <= 0;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) man_low_q <= 0;
      else if (!sync2_q.manual_n) man_low_q <= man_low_q + 1;
      else man_low_q <= 0;
   end
   complement_pair_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      reset_o != reset_n_o) else $error("reset pair not complementary");
   supply_fast_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !supply_ok_i |-> ##3 reset_o) else $error("supply low without reset");
   min_pulse_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $fell(reset_o) |-> low_run_q >= HOLD_CYC)
      else $error("reset pulse too short");
   supply_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !sync2_q.supply_ok |=> reset_o [*2])
      else $error("released during supply low");
   manual_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      pb_active_q |=> reset_o) else $error("manual reset not held");
   strobe_restart_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == csr_pkg::CSR_RUN && strobe_fall && !cause && !wd_expired)
      |=> cnt_q == 0) else $error("strobe did not restart");
   wd_idle_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      wd_expired && !cause |=> reset_o && cnt_q == 0)
      else $error("watchdog expiry missed");
   no_count_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == csr_pkg::CSR_HOLD && cause) |=> cnt_q == 0)
      else $error("hold timer ran with cause");
   debounce_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      sync2_q.manual_n |=> !pb_active_q)
      else $error("debounce kept stale press");
   debounce_min_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(pb_active_q) |-> man_low_q >= PB_CYC)
      else $error("press taken before debounce delay");
   cause_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      cause |=> reset_o) else $error("reset released with a cause");
   strobe_rise_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == csr_pkg::CSR_RUN && !cause && !wd_expired && !strobe_fall)
      |=> cnt_q == $past(cnt_q) + 1'h1)
      else $error("watchdog restarted without a fall");
   wd_fresh_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $fell(reset_o) |-> cnt_q == 0)
      else $error("watchdog counted during reset");
   release_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(reset_o));
   wd_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) wd_expired);
   pb_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(pb_active_q));
   strobe_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      state_q == csr_pkg::CSR_RUN && strobe_fall);
   supply_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(sync2_q.supply_ok));
endmodule

// file: verif/csr_cpu_model.sv
// cpu side model: strobes the watchdog while enabled
module csr_cpu_model (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic [4:0] gap_i,
   output logic strobe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial strobe_n_o = 1'h1;
   // one-cycle lows, falls spaced gap_i+1 cycles, below every period
   always @(negedge clk_i) begin
      cnt = (en_i && cnt < gap_i) ? cnt + 1 : 0;
      strobe_n_o <= !(en_i && cnt == 1);
   end
endmodule

// file: verif/tb.sv
// testbench: supervisor reset sequencing against a cpu model
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 20;
   localparam int PB = 5;
   localparam int WD [4] = '{30, 60, 90, 90};
   logic clk_i = 1'h0, rst_n_i = 1'h0, supply_ok = 1'h0, tolerance_select = 1'h0;
   logic [1:0] tsel = 2'h0;
   logic man_n = 1'h1, en = 1'h0, trip, rst, rst_n, strobe_n;
   logic [4:0] gap = 5'hA;
   int seed = 14, err_count = 0, cmp_count = 0;
   logic [1:0] exp_q[$];
   event chk_ev;
   always #10 clk_i = ~clk_i;
   csr_supervisor #(.HOLD_CYC(HOLD), .WD_SHORT_CYC(30), .WD_MID_CYC(60),
      .WD_LONG_CYC(90), .PB_CYC(PB)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .supply_ok_i(supply_ok), .tolerance_select_i(tolerance_select),
      .timeout_select_i(tsel), .watchdog_strobe_n_i(strobe_n),
      .manual_override_n_i(man_n), .trip_level_low_o(trip),
      .reset_o(rst), .reset_n_o(rst_n));
   csr_cpu_model cpu (.clk_i(clk_i), .en_i(en), .gap_i(gap),
      .strobe_n_o(strobe_n));
   ////////////////////////////////////////////////////////////////////////
   // monitor: oldest note against reset pair and trip level
   task cmp_reset(input logic [1:0] e);
      cmp_count++;
      if ({rst, rst_n, trip} !== {e[1], ~e[1], e[0]}) begin
         err_count++;
         $display("MISMATCH reset_pair_trip exp %b got %b",
            {e[1], ~e[1], e[0]}, {rst, rst_n, trip});
      end
   endtask
   always @(chk_ev) cmp_reset(exp_q.pop_front());
   task cyc(input int n);
      repeat (n) begin
         @(negedge clk_i);
         tolerance_select = 1'($random(seed));
      end
   endtask
   task chk(input logic v);
      #1;
      exp_q.push_back({v, tolerance_select});
      ->chk_ev;
   endtask
   // bounded wait on the reset output, then noted like any result
   task waitr(input logic v);
      for (int i = 0; i < 400 && rst !== v; i++) cyc(1);
      chk(v);
   endtask
   task results;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(10);
      rst_n_i = 1'h1;
      cyc(3);
      chk(1);
      supply_ok = 1'h1;
      cyc(HOLD);
      chk(1);
      cyc(6);
      chk(0);
      en = 1'h1;
      repeat (10) begin
         gap = 5'(9 + $unsigned($random(seed)) % 8);
         cyc(10);
         chk(0);
      end
      // bounce: lows far shorter than the debounce delay
      repeat (8) begin
         man_n = ~man_n;
         cyc(1);
      end
      cyc(4);
      chk(0);
      man_n = 1'h0;
      cyc(PB * 5);
      chk(1);
      man_n = 1'h1;
      cyc(HOLD - 2);
      chk(1);
      cyc(8);
      chk(0);
      supply_ok = 1'h0;
      cyc(3);
      chk(1);
      man_n = 1'h0;
      cyc(PB + 5);
      supply_ok = 1'h1;
      cyc(HOLD + 6);
      chk(1);
      man_n = 1'h1;
      cyc(HOLD - 2);
      chk(1);
      cyc(8);
      chk(0);
      en = 1'h0;
      waitr(1);
      for (int s = 0; s < 4; s++) begin
         tsel = 2'(s);
         waitr(0);
         cyc(WD[s] - 4);
         chk(0);
         cyc(10);
         chk(1);
         cyc(HOLD - 8);
         chk(1);
      end
      cyc(2);
      results;
   end
   // stall guard, well beyond the run of about 660 cycles
   initial begin
      #200000;
      err_count++;
      results;
   end
endmodule
